// File: rie_cfg.svh
// Purpose: constants for the reset and interrupt exception unit
// Assumes: 40 MHz system clock, 8-bit register port
// Notes: definitions only
`ifndef RIE_CFG_SVH
`define RIE_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RIE_ADDR_EDGE 4'h0
`define RIE_ADDR_EN_ONE 4'h1
`define RIE_ADDR_EN_TWO 4'h2
`define RIE_ADDR_FL_ONE 4'h3
`define RIE_ADDR_FL_TWO 4'h4
`define RIE_ADDR_WAKE 4'h5
`define RIE_ADDR_COND 4'h6
`define RIE_ADDR_STATUS 4'h7
`define RIE_ADDR_EN_THREE 4'h8
`define RIE_ADDR_FL_THREE 4'h9
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define RIE_EDGE_RESERVED 8'he0
`define RIE_BYTE_ZERO 8'h00
`define RIE_PINS_IDLE 8'hff
`define RIE_I_BIT 7
`define RIE_B1_TA 7
`define RIE_B1_S1 6
`define RIE_B1_WP 5
`define RIE_B2_DT 7
`define RIE_B2_AD 6
`define RIE_B2_S2 5
`define RIE_B2_TG 4
`define RIE_B2_TFH 3
`define RIE_B2_TFL 2
`define RIE_B2_TC 1
`define RIE_B2_TB 0
`define RIE_B3_S3 0
// ----------------------------------------
// Vectors and timing
// ----------------------------------------
`define RIE_VEC_RESET 5'h00
`define RIE_VEC_FIRST 5'h04
`define RIE_NUM_VEC 17
`define RIE_MODE_DELAY_CYC 8192
`define RIE_CNT_W 14
`endif

// File: rie_pkg.sv
// Purpose: types for the reset and interrupt exception unit
// Assumes: rie_cfg.svh holds the numbers
// Notes: one-hot sequencer codes
`default_nettype none
`include "rie_cfg.svh"
package rie_pkg;
    typedef enum logic [7:0] {
        ST_HOLD = 8'h01,
        ST_WAIT_MODE = 8'h02,
        ST_COUNT = 8'h04,
        ST_INIT = 8'h08,
        ST_FETCH_HI = 8'h10,
        ST_FETCH_LO = 8'h20,
        ST_LOAD = 8'h40,
        ST_RUN = 8'h80
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        logic [4:0] edge_sel;
        logic [7:0] en_one;
        logic [7:0] en_two;
        logic en_three;
        logic [7:0] fl_one;
        logic [7:0] fl_two;
        logic fl_three;
        logic [7:0] wake_fl;
        logic i_bit;
        logic first_insn;
        logic [4:0] vec;
        logic [15:0] vaddr;
        logic [15:0] pc;
        logic pc_load;
        logic [7:0] rdata;
        logic boot_prev;
        logic [4:0] irq_prev;
        logic [7:0] wake_prev;
        logic [`RIE_CNT_W-1:0] count;
    } rie_state_t;
endpackage
`default_nettype wire

// File: vector_arbiter.sv
// Purpose: fixed priority pick among vectors 4 to 20
// Assumes: bit 0 of req is vector 4
// Notes: lowest index wins
`timescale 1ns/1ps
`default_nettype none
`include "rie_cfg.svh"
module vector_arbiter (
    input wire logic [`RIE_NUM_VEC-1:0] req,
    output logic hit,
    output logic [4:0] vec
);
    // RL13: scan from lowest priority upward
    always_comb begin
        hit = 1'b0;
        vec = `RIE_VEC_FIRST;
        for (int i = `RIE_NUM_VEC - 1; i >= 0; i--) begin
            if (req[i]) begin
                hit = 1'b1;
                vec = 5'(i) + `RIE_VEC_FIRST;
            end
        end
    end
endmodule
`default_nettype wire

// File: reset_interrupt_exception.sv
// Purpose: reset sequencing and interrupt arbitration for a small core
// Assumes: core reports instruction boundaries; vector bytes arrive
//   one cycle after the fetch address
// Notes: all state lives in one struct register
// How it works
// RL1: reset outranks every interrupt
// RL2: interrupts taken only at instruction boundary
// RL3: reset pin low halts everything at once
// RL4: outside holds reset ten clocks minimum
// RL5: outside holds reset until clock stable
// RL6: mode high starts sequence on release
// RL7: mode low waits edge plus 8192 clocks
// RL8: init clears state, sets mask bit
// RL9: program counter loaded from vector zero
// RL10: first instruction always runs unmasked by interrupts
// RL11: software sets stack pointer first
// RL12: mask blocks acceptance, flags still set
// RL13: highest priority lowest vector wins
// RL14: edge pins select rising or falling
// RL15: edge pins use vectors four to eight
// RL16: wakeup pins share vector nine
// RL17: vectors ten to thirteen fixed sources
// RL18: vectors fourteen to sixteen merge pairs
// RL19: vectors seventeen to twenty assigned
// RL20: vector slots one to three unused
// RL21: polarity bits reset to falling edge
// RL22: flags clear only by writing zero
// RL23: enables reset off, gate acceptance
// RL24: first vector byte is high byte
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rie_cfg.svh"
module reset_interrupt_exception #(
    parameter int MODE_DELAY_CYCLES = `RIE_MODE_DELAY_CYC
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic BOOT_MODE_PIN,
    input wire logic [4:0] EDGE_INT_PINS,
    input wire logic [7:0] WAKEUP_PINS,
    input wire logic SERIAL_CHAN_ONE_DONE,
    input wire logic TIMER_A_OVF,
    input wire logic TIMER_B_OVF,
    input wire logic TIMER_C_OVF,
    input wire logic [1:0] TIMER_FL_EVT,
    input wire logic [1:0] TIMER_FH_EVT,
    input wire logic [1:0] TIMER_G_EVT,
    input wire logic [1:0] SERIAL_CHAN_TWO_EVT,
    input wire logic [5:0] SERIAL_CHAN_THREE_EVT,
    input wire logic CONV_END,
    input wire logic DIRECT_XFER,
    input wire logic CORE_INSN_BOUNDARY,
    input wire logic [7:0] VEC_RDATA,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic CORE_HOLD,
    output logic PERIPH_CLEAR,
    output logic VEC_REQ,
    output logic [15:0] VEC_ADDR,
    output logic PC_LOAD,
    output logic [15:0] PC_VALUE,
    output logic [4:0] EXC_VECTOR,
    output logic MASK_BIT
);
    import rie_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Two bytes per vector entry
    function automatic logic [15:0] vec_addr(input logic [4:0] v);
        vec_addr = {10'h000, v, 1'b0};
    endfunction

    // Set beats a clear in the same cycle
    function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic [7:0] clr);
        flag_next = (cur & ~clr) | set;
    endfunction

    function automatic logic is_wr(input logic [3:0] a);
        is_wr = REG_WR && (REG_ADDR == a);
    endfunction

    localparam logic [`RIE_CNT_W-1:0] DELAY_LAST = `RIE_CNT_W'(MODE_DELAY_CYCLES - 1);

    rie_state_t s;
    rie_state_t next_s;
    logic [4:0] irq_edge;
    logic [7:0] wake_edge;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] clr_one;
    logic [7:0] clr_two;
    logic [7:0] clr_wake;
    logic [7:0] clr_three;
    logic [`RIE_NUM_VEC-1:0] req;
    logic arb_hit;
    logic [4:0] arb_vec;
    logic take_int;

    // ----------------------------------------
    // Event detection
    // ----------------------------------------
    always_comb begin
        // RL14: per pin polarity choice
        for (int i = 0; i < 5; i++) begin
            if (s.edge_sel[i]) begin
                irq_edge[i] = ~s.irq_prev[i] & EDGE_INT_PINS[i];
            end else begin
                irq_edge[i] = s.irq_prev[i] & ~EDGE_INT_PINS[i];
            end
        end
        // Wakeup pins are active low
        wake_edge = s.wake_prev & ~WAKEUP_PINS;
    end

    // RL18: merged timer and serial events
    assign set_one = {TIMER_A_OVF, SERIAL_CHAN_ONE_DONE, 1'b0, irq_edge};
    assign set_two = {DIRECT_XFER, CONV_END, |SERIAL_CHAN_TWO_EVT, |TIMER_G_EVT,
                      |TIMER_FH_EVT, |TIMER_FL_EVT, TIMER_C_OVF, TIMER_B_OVF};

    // ----------------------------------------
    // Flag clears
    // ----------------------------------------
    // Process, not assigns: is_wr reads the strobe itself
    // RL22: written zero clears, one keeps
    always_comb begin
        clr_one = is_wr(`RIE_ADDR_FL_ONE) ? ~REG_WDATA : `RIE_BYTE_ZERO;
        clr_two = is_wr(`RIE_ADDR_FL_TWO) ? ~REG_WDATA : `RIE_BYTE_ZERO;
        clr_wake = is_wr(`RIE_ADDR_WAKE) ? ~REG_WDATA : `RIE_BYTE_ZERO;
        clr_three = is_wr(`RIE_ADDR_FL_THREE) ? ~REG_WDATA : `RIE_BYTE_ZERO;
    end

    // ----------------------------------------
    // Request vector
    // ----------------------------------------
    always_comb begin
        // RL23: flag and enable both needed
        // RL15: edge pins on vectors 4 to 8
        req[4:0] = s.fl_one[4:0] & s.en_one[4:0];
        // RL16: all wakeup pins on vector 9
        req[5] = (|s.wake_fl) & s.en_one[`RIE_B1_WP];
        // RL17: vectors 10 to 13
        req[6] = s.fl_one[`RIE_B1_S1] & s.en_one[`RIE_B1_S1];
        req[7] = s.fl_one[`RIE_B1_TA] & s.en_one[`RIE_B1_TA];
        req[8] = s.fl_two[`RIE_B2_TB] & s.en_two[`RIE_B2_TB];
        req[9] = s.fl_two[`RIE_B2_TC] & s.en_two[`RIE_B2_TC];
        req[10] = s.fl_two[`RIE_B2_TFL] & s.en_two[`RIE_B2_TFL];
        req[11] = s.fl_two[`RIE_B2_TFH] & s.en_two[`RIE_B2_TFH];
        req[12] = s.fl_two[`RIE_B2_TG] & s.en_two[`RIE_B2_TG];
        // RL19: vectors 17 to 20
        req[13] = s.fl_two[`RIE_B2_S2] & s.en_two[`RIE_B2_S2];
        req[14] = s.fl_three & s.en_three;
        req[15] = s.fl_two[`RIE_B2_AD] & s.en_two[`RIE_B2_AD];
        req[16] = s.fl_two[`RIE_B2_DT] & s.en_two[`RIE_B2_DT];
    end

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    // RL20: arbiter never yields vectors 1 to 3
    vector_arbiter i_vector_arbiter (
        .req(req),
        .hit(arb_hit),
        .vec(arb_vec)
    );

    // ----------------------------------------
    // Acceptance
    // ----------------------------------------
    // RL2: only at a boundary while running
    // RL10: first instruction shields the stack setup
    // RL12: mask bit blocks acceptance only
    assign take_int = (s.state == ST_RUN) && CORE_INSN_BOUNDARY && arb_hit
                      && !s.i_bit && !s.first_insn;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.pc_load = 1'b0;
        next_s.rdata = `RIE_BYTE_ZERO;
        next_s.irq_prev = EDGE_INT_PINS;
        next_s.wake_prev = WAKEUP_PINS;
        next_s.boot_prev = BOOT_MODE_PIN;

        // RL12: flags set even when masked
        next_s.fl_one = flag_next(s.fl_one, set_one, clr_one);
        next_s.fl_two = flag_next(s.fl_two, set_two, clr_two);
        next_s.wake_fl = flag_next(s.wake_fl, wake_edge, clr_wake);
        next_s.fl_three = (s.fl_three & ~clr_three[`RIE_B3_S3]) | (|SERIAL_CHAN_THREE_EVT);

        if (is_wr(`RIE_ADDR_EDGE)) begin
            next_s.edge_sel = REG_WDATA[4:0];
        end
        if (is_wr(`RIE_ADDR_EN_ONE)) begin
            next_s.en_one = REG_WDATA;
        end
        if (is_wr(`RIE_ADDR_EN_TWO)) begin
            next_s.en_two = REG_WDATA;
        end
        if (is_wr(`RIE_ADDR_EN_THREE)) begin
            next_s.en_three = REG_WDATA[`RIE_B3_S3];
        end
        if (is_wr(`RIE_ADDR_COND)) begin
            next_s.i_bit = REG_WDATA[`RIE_I_BIT];
        end

        if (REG_RD) begin
            unique case (REG_ADDR)
                `RIE_ADDR_EDGE: next_s.rdata = `RIE_EDGE_RESERVED | {3'b000, s.edge_sel};
                `RIE_ADDR_EN_ONE: next_s.rdata = s.en_one;
                `RIE_ADDR_EN_TWO: next_s.rdata = s.en_two;
                `RIE_ADDR_FL_ONE: next_s.rdata = s.fl_one;
                `RIE_ADDR_FL_TWO: next_s.rdata = s.fl_two;
                `RIE_ADDR_WAKE: next_s.rdata = s.wake_fl;
                `RIE_ADDR_COND: next_s.rdata = {s.i_bit, 7'h00};
                `RIE_ADDR_STATUS: next_s.rdata = {s.first_insn, arb_hit, 1'b0, s.vec};
                `RIE_ADDR_EN_THREE: next_s.rdata = {7'h00, s.en_three};
                `RIE_ADDR_FL_THREE: next_s.rdata = {7'h00, s.fl_three};
                default: next_s.rdata = `RIE_BYTE_ZERO;
            endcase
        end

        unique case (s.state)
            // RL6: first edge after release reads the strap
            ST_HOLD: begin
                next_s.count = '0;
                if (BOOT_MODE_PIN) begin
                    next_s.state = ST_INIT;
                end else begin
                    next_s.state = ST_WAIT_MODE;
                end
            end
            // RL7: low to high on the mode pin
            ST_WAIT_MODE: begin
                if (!s.boot_prev && BOOT_MODE_PIN) begin
                    next_s.state = ST_COUNT;
                end
            end
            // RL7: fixed delay before release
            ST_COUNT: begin
                next_s.count = s.count + 1'b1;
                if (s.count == DELAY_LAST) begin
                    next_s.state = ST_INIT;
                end
            end
            // RL8: peripherals cleared, mask set
            ST_INIT: begin
                next_s.i_bit = 1'b1;
                next_s.vec = `RIE_VEC_RESET;
                next_s.vaddr = vec_addr(`RIE_VEC_RESET);
                next_s.first_insn = 1'b1;
                next_s.state = ST_FETCH_HI;
            end
            // Address steps on to the low byte
            ST_FETCH_HI: begin
                next_s.vaddr = s.vaddr + 16'h0001;
                next_s.state = ST_FETCH_LO;
            end
            // RL24: high byte from lower address
            ST_FETCH_LO: begin
                next_s.pc = {VEC_RDATA, 8'h00};
                next_s.state = ST_LOAD;
            end
            // RL9: jump to the fetched address
            ST_LOAD: begin
                next_s.pc = {s.pc[15:8], VEC_RDATA};
                next_s.pc_load = 1'b1;
                next_s.state = ST_RUN;
            end
            ST_RUN: begin
                // Boundary in the load cycle belongs to the jump
                if (CORE_INSN_BOUNDARY && !s.pc_load) begin
                    next_s.first_insn = 1'b0;
                end
                // RL13: winner of the arbiter only
                if (take_int) begin
                    next_s.i_bit = 1'b1;
                    next_s.vec = arb_vec;
                    next_s.vaddr = vec_addr(arb_vec);
                    next_s.state = ST_FETCH_HI;
                end
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // RL1: reset overrides any pending interrupt
    // RL3: low reset forces the hold state
    // RL21: polarity bits clear to falling edge
    // RL23: enables clear to off
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            s.state <= ST_HOLD;
            s.edge_sel <= '0;
            s.en_one <= `RIE_BYTE_ZERO;
            s.en_two <= `RIE_BYTE_ZERO;
            s.en_three <= 1'b0;
            s.fl_one <= `RIE_BYTE_ZERO;
            s.fl_two <= `RIE_BYTE_ZERO;
            s.fl_three <= 1'b0;
            s.wake_fl <= `RIE_BYTE_ZERO;
            s.i_bit <= 1'b1;
            s.first_insn <= 1'b1;
            s.vec <= `RIE_VEC_RESET;
            s.vaddr <= '0;
            s.pc <= '0;
            s.pc_load <= 1'b0;
            s.rdata <= `RIE_BYTE_ZERO;
            s.boot_prev <= 1'b0;
            s.irq_prev <= '1;
            s.wake_prev <= `RIE_PINS_IDLE;
            s.count <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Core stays stalled through any vector fetch
    assign CORE_HOLD = (s.state != ST_RUN);
    assign PERIPH_CLEAR = s.state inside {ST_HOLD, ST_WAIT_MODE, ST_COUNT, ST_INIT};
    assign VEC_REQ = s.state inside {ST_FETCH_HI, ST_FETCH_LO};
    assign VEC_ADDR = s.vaddr;
    assign PC_LOAD = s.pc_load;
    assign PC_VALUE = s.pc;
    assign EXC_VECTOR = s.vec;
    assign MASK_BIT = s.i_bit;
    assign REG_RDATA = s.rdata;
endmodule
`default_nettype wire

// File: rie_sva.sv
// Purpose: port checks for reset_interrupt_exception
// Assumes: vector bytes arrive one cycle after their address
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rie_sva #(
    parameter int MODE_DELAY_CYCLES = 8
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic BOOT_MODE_PIN,
    input wire logic CORE_INSN_BOUNDARY,
    input wire logic [7:0] VEC_RDATA,
    input wire logic CORE_HOLD,
    input wire logic PERIPH_CLEAR,
    input wire logic VEC_REQ,
    input wire logic [15:0] VEC_ADDR,
    input wire logic PC_LOAD,
    input wire logic [15:0] PC_VALUE,
    input wire logic MASK_BIT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // ----
    // Fetch steps
    // ----
    sequence s_second_byte;
        VEC_REQ && VEC_ADDR == $past(VEC_ADDR) + 16'h1;
    endsequence
    sequence s_fetch_tail;
        s_second_byte ##1 !VEC_REQ ##1 PC_LOAD;
    endsequence
    property p_fetch;
        $rose(VEC_REQ) |=> s_fetch_tail;
    endproperty
    property p_bytes;
        PC_LOAD |-> PC_VALUE == {$past(VEC_RDATA, 2), $past(VEC_RDATA)};
    endproperty
    property p_run;
        PC_LOAD |-> !CORE_HOLD && !PERIPH_CLEAR ##1 !PC_LOAD;
    endproperty
    property p_mask_fetch;
        $rose(VEC_REQ) |-> MASK_BIT;
    endproperty
    property p_masked;
        MASK_BIT && !CORE_HOLD |=> !VEC_REQ;
    endproperty
    property p_shield;
        PC_LOAD |=> !VEC_REQ [*2];
    endproperty
    property p_boundary;
        $rose(VEC_REQ) && !$past(CORE_HOLD) |-> $past(CORE_INSN_BOUNDARY);
    endproperty
    property p_slot;
        $rose(VEC_REQ) |-> VEC_ADDR == 16'h0 || (VEC_ADDR inside {[16'h8:16'h28]} && !VEC_ADDR[0]);
    endproperty
    property p_release;
        $rose(RESETN) |-> CORE_HOLD && PERIPH_CLEAR && MASK_BIT;
    endproperty
    // Long count stays a parameter; eight is the floor
    property p_mode_wait;
        $rose(BOOT_MODE_PIN) && PERIPH_CLEAR |-> !VEC_REQ [*8];
    endproperty
    a_fetch: assert property (p_fetch) else $error("vector fetch out of order");
    a_bytes: assert property (p_bytes) else $error("load value not high then low byte");
    a_run: assert property (p_run) else $error("load pulse while halted");
    a_mask_fetch: assert property (p_mask_fetch) else $error("mask clear during fetch");
    a_masked: assert property (p_masked) else $error("fetch while masked");
    a_shield: assert property (p_shield) else $error("fetch before first instruction");
    a_boundary: assert property (p_boundary) else $error("fetch inside an instruction");
    a_slot: assert property (p_slot) else $error("reserved vector slot used");
    a_release: assert property (p_release) else $error("not halted at release");
    a_mode_wait: assert property (p_mode_wait) else $error("mode delay too short");
endmodule
bind reset_interrupt_exception rie_sva #(.MODE_DELAY_CYCLES(MODE_DELAY_CYCLES)) i_rie_sva (
    .CLOCK, .RESETN, .BOOT_MODE_PIN, .CORE_INSN_BOUNDARY, .VEC_RDATA, .CORE_HOLD,
    .PERIPH_CLEAR, .VEC_REQ, .VEC_ADDR, .PC_LOAD, .PC_VALUE, .MASK_BIT);
`default_nettype wire

// File: core_model.sv
// Purpose: core stand-in, vector memory and instruction ends
// Assumes: byte at address a is a xor 5a (even) or c3 (odd)
// Notes: slow spaces instruction ends four cycles apart
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic CLOCK,
    input wire logic slow,
    input wire logic CORE_HOLD,
    input wire logic VEC_REQ,
    input wire logic [15:0] VEC_ADDR,
    output logic CORE_INSN_BOUNDARY,
    output logic [7:0] VEC_RDATA
);
    logic [1:0] cnt = 2'h0;
    initial VEC_RDATA = 8'h00;
    assign CORE_INSN_BOUNDARY = !CORE_HOLD && cnt == 2'h0;
    always @(posedge CLOCK) begin
        cnt <= (CORE_HOLD || !slow) ? 2'h0 : cnt + 2'h1;
        // Idle bus toggles so no stale byte looks valid
        VEC_RDATA <= VEC_REQ ? VEC_ADDR[7:0] ^ (VEC_ADDR[0] ? 8'hc3 : 8'h5a) : ~VEC_RDATA;
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: directed bench for reset_interrupt_exception
// Assumes: mode delay shortened to eight clocks
// Notes: every source is taken once, except that wakeup pin 0 is the only wakeup pin driven
`timescale 1ns/1ps
`default_nettype none
`include "rie_cfg.svh"
module testbench;
    localparam int DLY = 8;
    logic CLOCK, RESETN, boot, slow, wr, rd, hold, pclr, vreq, pcl, mask, bnd;
    logic [4:0] irq, exc;
    logic [7:0] wake, wdata, rdata, vdata, d;
    logic [3:0] addr, ea;
    logic [19:0] src;
    logic [15:0] vaddr, pcv;
    int n_fail, total_checks, i, n, v, eb;
    logic [3:0] ra [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hf};
    logic [7:0] rv [9] = '{8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    reset_interrupt_exception #(.MODE_DELAY_CYCLES(DLY)) i_reset_interrupt_exception (
        .CLOCK, .RESETN, .BOOT_MODE_PIN(boot), .EDGE_INT_PINS(irq), .WAKEUP_PINS(wake),
        .SERIAL_CHAN_ONE_DONE(src[0]), .TIMER_A_OVF(src[1]), .TIMER_B_OVF(src[2]),
        .TIMER_C_OVF(src[3]), .TIMER_FL_EVT(src[5:4]), .TIMER_FH_EVT(src[7:6]),
        .TIMER_G_EVT(src[9:8]), .SERIAL_CHAN_TWO_EVT(src[11:10]), .SERIAL_CHAN_THREE_EVT(src[17:12]),
        .CONV_END(src[18]), .DIRECT_XFER(src[19]), .CORE_INSN_BOUNDARY(bnd), .VEC_RDATA(vdata),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .CORE_HOLD(hold), .PERIPH_CLEAR(pclr), .VEC_REQ(vreq), .VEC_ADDR(vaddr),
        .PC_LOAD(pcl), .PC_VALUE(pcv), .EXC_VECTOR(exc), .MASK_BIT(mask));
    core_model i_core_model (.CLOCK, .slow, .CORE_HOLD(hold), .VEC_REQ(vreq), .VEC_ADDR(vaddr),
        .CORE_INSN_BOUNDARY(bnd), .VEC_RDATA(vdata));
    initial begin
        CLOCK = 0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    // ----
    // Tasks
    // ----
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] wd);
        @(posedge CLOCK);
        wr <= 1;
        addr <= a;
        wdata <= wd;
        @(posedge CLOCK);
        wr <= 0;
    endtask
    task automatic rchk(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge CLOCK);
        rd <= 1;
        addr <= a;
        @(posedge CLOCK);
        rd <= 0;
        #1 chk(name, {8'h0, exp}, {8'h0, rdata});
    endtask
    task automatic wait_load;
        n = 0;
        do begin
            @(posedge CLOCK);
            #1 n++;
            if (n > 400) begin
                chk("load pulse", 16'h1, 16'h0);
                give_verdict();
            end
        end while (pcl !== 1'b1);
    endtask
    function automatic logic [15:0] exp_pc(input int vn);
        logic [7:0] a;
        a = 8'(2 * vn);
        return {a ^ 8'h5a, (a + 8'h1) ^ 8'hc3};
    endfunction
    task automatic take(input int vn);
        wr_reg(`RIE_ADDR_COND, 8'h00);
        wait_load();
        chk("exception vector", 16'(vn), {11'h0, exc});
        chk("load value", exp_pc(vn), pcv);
        chk("mask bit", 16'h1, {15'h0, mask});
    endtask
    task automatic do_reset(input logic b);
        @(posedge CLOCK);
        boot <= b;
        RESETN <= 0;
        #1 chk("core hold", 16'h1, {15'h0, hold});
        repeat (10) @(posedge CLOCK);
        RESETN <= 1;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        RESETN = 0;
        {boot, slow, wr, rd, addr, wdata, src} = '0;
        irq = 5'h1f;
        wake = 8'hff;
        n_fail = 0;
        total_checks = 0;
        do_reset(1);
        wait_load();
        chk("load value", exp_pc(0), pcv);
        chk("exception vector", 16'h0, {11'h0, exc});
        for (i = 0; i < 9; i++) rchk("reset value", ra[i], rv[i]);
        $display("test reset done");
        do_reset(0);
        repeat (20) @(posedge CLOCK);
        #1 chk("core hold", 16'h1, {15'h0, hold});
        @(posedge CLOCK) boot <= 1;
        wait_load();
        chk("mode delay", 16'(DLY + 5), 16'(n));
        $display("test mode low done");
        wr_reg(`RIE_ADDR_EDGE, 8'h1f);
        rchk("edge select", `RIE_ADDR_EDGE, 8'hff);
        @(posedge CLOCK) irq <= 5'h00;
        repeat (3) @(posedge CLOCK);
        rchk("flags falling", `RIE_ADDR_FL_ONE, 8'h00);
        @(posedge CLOCK) irq <= 5'h1f;
        repeat (3) @(posedge CLOCK);
        rchk("flags rising", `RIE_ADDR_FL_ONE, 8'h1f);
        wr_reg(`RIE_ADDR_FL_ONE, 8'hff);
        rchk("flags kept", `RIE_ADDR_FL_ONE, 8'h1f);
        wr_reg(`RIE_ADDR_EN_ONE, 8'h1f);
        for (i = 0; i < 5; i++) begin
            take(4 + i);
            wr_reg(`RIE_ADDR_FL_ONE, ~(8'h1 << i));
        end
        wr_reg(`RIE_ADDR_EDGE, 8'h00);
        @(posedge CLOCK) irq <= 5'h00;
        repeat (3) @(posedge CLOCK);
        rchk("falling flags set", `RIE_ADDR_FL_ONE, 8'h1f);
        wr_reg(`RIE_ADDR_FL_ONE, 8'he0);
        @(posedge CLOCK) irq <= 5'h1f;
        repeat (3) @(posedge CLOCK);
        rchk("rising ignored", `RIE_ADDR_FL_ONE, 8'h00);
        wr_reg(`RIE_ADDR_EN_ONE, 8'h20);
        @(posedge CLOCK) wake <= 8'hfe;
        @(posedge CLOCK) wake <= 8'hff;
        take(9);
        wr_reg(`RIE_ADDR_WAKE, 8'hfe);
        wr_reg(`RIE_ADDR_EN_ONE, 8'h00);
        $display("test external done");
        slow <= 1;
        for (i = 0; i < 20; i++) begin
            v = i < 4 ? 10 + i : (i < 12 ? 14 + (i - 4) / 2 : (i < 18 ? 18 : i + 1));
            ea = v < 12 ? 4'h1 : (v == 18 ? 4'h8 : 4'h2);
            eb = v == 10 ? 6 : (v == 11 ? 7 : (v == 18 ? 0 : (v > 18 ? v - 13 : v - 12)));
            @(posedge CLOCK) src <= 20'h1 << i;
            @(posedge CLOCK) src <= 20'h0;
            wr_reg(ea, 8'h1 << eb);
            take(v);
            wr_reg(ea, 8'h00);
            wr_reg(ea == 4'h8 ? 4'h9 : ea + 4'h2, ~(8'h1 << eb));
        end
        rchk("status", `RIE_ADDR_STATUS, 8'h14);
        $display("test internal done");
        give_verdict();
    end
endmodule
`default_nettype wire
